// ---- bench/ssp_ctrl_chk.sv ----
// Pin and stream checks for the serial port controller.
// Assumes a bind into ssp_ctrl; setup changes only while idle.
module ssp_ctrl_chk (
  // Clock, reset, setup
  input wire       sys_clk,
  input wire       rst,
  input wire       enable,
  input wire       master_mode,
  input wire [1:0] bus_format,
  input wire       clk_polarity,
  // Streams
  input wire       tx_ready,
  input wire [3:0] tx_level,
  input wire [3:0] rx_level,
  input wire       rx_ready,
  input wire       busy,
  input wire       overrun_r,
  input wire       overrun_clr,
  // Pins
  input wire       sclk_out_r,
  input wire       sclk_oe,
  input wire       frame_sync_line_in,
  input wire       frame_sync_line_out_r,
  input wire       frame_sync_line_oe,
  input wire       miso_oe,
  input wire       mosi_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire act = enable && master_mode;
  sclk_idle_a: assert property (
    act && !busy && !$past(busy) && !$past(rst) && $past(bus_format, 2) == bus_format
    && $past(clk_polarity, 2) == clk_polarity
    |-> sclk_out_r == (bus_format == 2'h0 && clk_polarity)) else $error("sclk idle level");
  fs_wraps_a: assert property (
    act && bus_format != 2'h1 && frame_sync_line_out_r && $past(frame_sync_line_out_r)
    && $past(clk_polarity, 2) == clk_polarity |-> $stable(sclk_out_r))
    else $error("sclk moved outside select");
  fs_idle_a: assert property (
    act && !busy && !$past(busy) && !$past(rst) && $past(bus_format, 2) == bus_format
    |-> frame_sync_line_out_r == (bus_format != 2'h1)) else $error("select idle level");
  ssi_pulse_a: assert property (
    act && bus_format == 2'h1 && $rose(frame_sync_line_out_r)
    |-> ##[1:256] !frame_sync_line_out_r) else $error("frame pulse too long");
  role_oe_a: assert property (
    act |-> sclk_oe && frame_sync_line_oe && mosi_oe && !miso_oe) else $error("master enables");
  slave_hiz_a: assert property (
    (enable && !master_mode && bus_format == 2'h0 && frame_sync_line_in) [*4]
    |-> !miso_oe && !mosi_oe) else $error("unselected slave drives");
  tx_full_a: assert property (
    tx_level <= 4'h8 && tx_ready == (tx_level != 4'h8)) else $error("tx ready vs level");
  no_data_a: assert property (
    act && !busy && tx_level == 4'h0 |=> !busy) else $error("frame without data");
  rx_drop_a: assert property (
    rx_level == 4'h8 && !rx_ready |=> rx_level == 4'h8) else $error("rx level moved");
  ovr_set_a: assert property (
    $rose(overrun_r) |-> $past(rx_level) == 4'h8) else $error("overrun while not full");
  ovr_hold_a: assert property (
    overrun_r && !overrun_clr |=> overrun_r) else $error("overrun not sticky");
endmodule

// ---- bench/ssp_slave_model.sv ----
// Behavioural serial slave facing the controller in master role.
// Assumes pins already resolved by the bench.
module ssp_slave_model (
  // Pins
  input  wire        sclk,
  input  wire        fs,
  input  wire        mosi,
  output reg         miso,
  // Setup and capture
  input  wire [1:0]  fmt,
  input  wire        pol,
  input  wire [3:0]  size,
  input  wire [15:0] resp,
  output reg  [15:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] idx = 4'h0;
  wire lead = (fmt == 2'h0) ? ~pol : 1'b1;
  initial miso = 1'b0;
  initial got = 16'h0000;
  // single slave on the master select
  always @(fs) begin
    if (fs == (fmt == 2'h1)) begin
      got = 16'h0000;
      idx = size;
      miso = resp[size];
    end else if (fmt != 2'h1) begin
      miso = ~miso;
    end
  end
  // sample on leading edge, shift on trailing
  always @(sclk) begin
    if (sclk === lead) begin
      got = {got[14:0], mosi};
    end else if (idx != 4'h0) begin
      idx = idx - 4'h1;
      miso = resp[idx];
    end else begin
      miso = ~miso;
    end
  end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench: master role against the slave model, slave role driven here.
// Assumes the rtl folder is on the include path.
`include "ssp_consts.vh"
`define CK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
`define WT(c) begin i = 0; while (!(c) && i < 20000) begin @(posedge sys_clk); i++; end \
  if (!(c)) begin err_total++; final_report; end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg         sys_clk, rst = 1'b1, enable = 1'b1, master_mode = 1'b1;
  reg         clk_polarity = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  reg         overrun_clr = 1'b0, fs_drv = 1'b1, sclk_drv = 1'b0, mosi_drv = 1'b0;
  reg  [1:0]  bus_format = 2'h0;
  reg  [3:0]  frame_size = 4'h7;
  reg  [7:0]  clk_div = 8'h09;
  reg  [15:0] tx_data = 16'h0000, resp = 16'h0000, d, m, s;
  wire        tx_ready, rx_valid, busy, overrun_r, sclk_out_r, sclk_oe, slv_miso;
  wire        frame_sync_line_out_r, frame_sync_line_oe, miso_out_r, miso_oe;
  wire        mosi_out_r, mosi_oe;
  wire [15:0] rx_data, got;
  wire [3:0]  tx_level, rx_level;
  int         err_total = 0, total_checks = 0, i, f, k;
  // Undriven lines: select held idle, clock and mosi held low, miso from the slave model
  wire sclk_in = sclk_oe ? sclk_out_r : sclk_drv;
  wire frame_sync_line_in = frame_sync_line_oe ? frame_sync_line_out_r : fs_drv;
  wire miso_in = miso_oe ? miso_out_r : slv_miso;
  wire mosi_in = mosi_oe ? mosi_out_r : mosi_drv;
  ssp_ctrl u_ssp_ctrl (.sys_clk, .rst, .enable, .master_mode, .bus_format, .frame_size,
    .clk_polarity, .clk_div, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .tx_level, .rx_level, .busy, .overrun_r, .overrun_clr, .sclk_in, .sclk_out_r, .sclk_oe,
    .frame_sync_line_in, .frame_sync_line_out_r, .frame_sync_line_oe, .miso_in, .miso_out_r,
    .miso_oe, .mosi_in, .mosi_out_r, .mosi_oe);
  ssp_slave_model u_ssp_slave_model (.sclk(sclk_in), .fs(frame_sync_line_in), .mosi(mosi_in),
    .miso(slv_miso), .fmt(bus_format), .pol(clk_polarity), .size(frame_size), .resp, .got);
  function [15:0] fmask(input [3:0] sz);
    fmask = 16'((32'h1 << (sz + 1)) - 1);
  endfunction
  // Third format ignores the return line
  function [15:0] exp_rx;
    exp_rx = (bus_format == `SSP_FMT_ALT) ? 16'h0000 : resp & fmask(frame_size);
  endfunction
  task final_report;
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task push(input [15:0] v);
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    tx_data <= v;
    @(posedge sys_clk);
    `WT(tx_ready === 1'b1)
    tx_valid <= 1'b0;
  endtask
  task pop(input [15:0] e);
    @(posedge sys_clk);
    `WT(rx_valid === 1'b1)
    `CK("rx_data", e, rx_data)
    rx_ready <= 1'b1;
    @(posedge sys_clk);
    rx_ready <= 1'b0;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    i = $urandom(41);
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (f = 0; f < 4; f++) begin
      for (k = 0; k < 5; k++) begin
        @(posedge sys_clk);
        bus_format <= (f < 2) ? `SSP_FMT_SPI : 2'(f - 1);
        clk_polarity <= (f == 1);
        frame_size <= (k == 0) ? 4'h3 : (k == 1) ? 4'hF : 4'(3 + $urandom % 13);
        resp <= 16'($urandom);
        d = 16'($urandom);
        push(d);
        pop(exp_rx());
        `CK("mosi_bits", d & fmask(frame_size), got)
      end
    end
    // Fill while stopped, then overflow the receive side
    enable <= 1'b0;
    for (k = 0; k < 8; k++) push(16'(k * 16'h1111));
    @(posedge sys_clk);
    `CK("tx_ready_full", 1'b0, tx_ready)
    `CK("tx_level_full", 4'h8, tx_level)
    enable <= 1'b1;
    push(16'hA5C3);
    `WT(overrun_r === 1'b1)
    `CK("rx_level_full", 4'h8, rx_level)
    for (k = 0; k < 8; k++) pop(exp_rx());
    @(posedge sys_clk);
    `CK("rx_level_empty", 4'h0, rx_level)
    `CK("overrun_sticky", 1'b1, overrun_r)
    overrun_clr <= 1'b1;
    @(posedge sys_clk);
    overrun_clr <= 1'b0;
    @(posedge sys_clk);
    `CK("overrun_clr", 1'b0, overrun_r)
    master_mode <= 1'b0;
    bus_format <= `SSP_FMT_SPI;
    repeat (6) @(posedge sys_clk);
    `CK("miso_oe_idle", 1'b0, miso_oe)
    `CK("mosi_oe_slave", 1'b0, mosi_oe)
    // Slave role: bench plays master, 160 ns per bit
    d = 16'($urandom);
    m = 16'($urandom);
    s = 16'h0000;
    push(d);
    fs_drv <= 1'b0;
    repeat (6) @(posedge sys_clk);
    `CK("miso_oe_sel", 1'b1, miso_oe)
    for (k = 15; k >= 0; k--) if (k <= frame_size) begin
      mosi_drv <= m[k];
      repeat (10) @(posedge sys_clk);
      s = {s[14:0], miso_in};
      sclk_drv <= 1'b1;
      repeat (10) @(posedge sys_clk);
      sclk_drv <= 1'b0;
    end
    pop(m & fmask(frame_size));
    `CK("slave_miso", d & fmask(frame_size), s)
    final_report;
  end
endmodule
bind ssp_ctrl ssp_ctrl_chk u_ssp_ctrl_chk (.sys_clk, .rst, .enable, .master_mode, .bus_format,
  .clk_polarity, .tx_ready, .tx_level, .rx_level, .rx_ready, .busy, .overrun_r, .overrun_clr,
  .sclk_out_r, .sclk_oe, .frame_sync_line_in, .frame_sync_line_out_r, .frame_sync_line_oe,
  .miso_oe, .mosi_oe);

// ---- rtl/ssp_consts.vh ----
// Constants for the sync serial port controller.
// Assumes inclusion by bare name from rtl/ and bench/ files.
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// Bus formats
`define SSP_FMT_SPI      2'h0
`define SSP_FMT_SSI      2'h1
`define SSP_FMT_ALT      2'h2

// Frame size code: bits = code + 1, legal 3..15
`define SSP_SIZE_MIN     4'h3
`define SSP_DATA_W       16
`define SSP_FIFO_DEPTH   8
`define SSP_FIFO_AW      3
`define SSP_CNT_W        4

// Divider reset value (half serial period minus one, in sys clocks)
`define SSP_DIV_RST      8'h04

`endif

// ---- rtl/ssp_ctrl.v ----
// Sync serial port controller: master or slave, three frame formats.
// Assumes pins pass through an outside pad ring resolving the enables.
//
// Functional notes
// [R1] Three formats share the same four pins
// [R2] Master or slave role is selectable
// [R3] Separate eight-frame transmit and receive FIFOs
// [R4] Frames 4 to 16 bits, full duplex
// [R5] One master, one slave per transfer
// [R6] Master makes clock; slave shifts on it
// [R7] Polarity selectable in SPI only
// [R8] Clock toggles only during frames
// [R9] Master asserts select before data, releases after; in SSI the code ends the pulse in ST_LEAD, before the first bit
// [R10] Select level depends on format
// [R11] Slave qualifies data by incoming select
// [R12] Slave drives return line; master samples it except in ALT format
// [R13] Unselected slave leaves return line undriven
// [R14] Master drives outgoing line; slave samples
// [R15] Outside logic gates selects for many slaves
// [R16] Pin direction follows current role
// [R17] Master starts only with transmit data queued
// [R18] Full receive FIFO drops frame, sets overrun
`include "ssp_consts.vh"

module ssp_ctrl (
  // Clock and reset
  input  wire                     sys_clk,
  input  wire                     rst,
  // Configuration
  input  wire                     enable,
  input  wire                     master_mode,
  input  wire [1:0]               bus_format,
  input  wire [3:0]               frame_size,
  input  wire                     clk_polarity,
  input  wire [7:0]               clk_div,
  // Transmit stream
  input  wire                     tx_valid,
  output wire                     tx_ready,
  input  wire [`SSP_DATA_W-1:0]   tx_data,
  // Receive stream
  output wire                     rx_valid,
  input  wire                     rx_ready,
  output wire [`SSP_DATA_W-1:0]   rx_data,
  // Status
  output wire [`SSP_FIFO_AW:0]    tx_level,
  output wire [`SSP_FIFO_AW:0]    rx_level,
  output wire                     busy,
  output reg                      overrun_r,
  input  wire                     overrun_clr,
  // Serial clock pin
  input  wire                     sclk_in,
  output reg                      sclk_out_r,
  output wire                     sclk_oe,
  // Frame sync / select pin
  input  wire                     frame_sync_line_in,
  output reg                      frame_sync_line_out_r,
  output wire                     frame_sync_line_oe,
  // Master-in slave-out pin
  input  wire                     miso_in,
  output reg                      miso_out_r,
  output wire                     miso_oe,
  // Master-out slave-in pin
  input  wire                     mosi_in,
  output reg                      mosi_out_r,
  output wire                     mosi_oe
);

  // ************************************************************
  // State and helpers
  // ************************************************************
  localparam ST_IDLE  = 2'h0;
  localparam ST_LEAD  = 2'h1;
  localparam ST_SHIFT = 2'h2;
  localparam ST_TAIL  = 2'h3;

  reg  [1:0]             st_r;
  reg  [7:0]             div_r;
  reg  [`SSP_CNT_W-1:0]  bit_r;
  reg                    phase_r;
  reg  [`SSP_DATA_W-1:0] sh_tx_r;
  reg  [`SSP_DATA_W-1:0] sh_rx_r;
  reg                    rx_push_r;
  reg  [`SSP_DATA_W-1:0] rx_word_r;
  reg  [3:0]             size_r;

  // Pin synchronisers: first stage read by second only
  reg  [1:0] sclk_s_r;
  reg  [1:0] fs_s_r;
  reg  [1:0] miso_s_r;
  reg  [1:0] mosi_s_r;
  reg        sclk_d_r;
  reg        fs_d_r;

  wire [`SSP_DATA_W-1:0] tx_q;
  wire                   tx_q_valid;
  wire                   tx_pop;
  wire                   rx_wr_ready;
  wire                   rx_push;

  // [R7] Polarity only in SPI
  function idle_level;
    input [1:0] fmt;
    input       pol;
    begin
      idle_level = (fmt == `SSP_FMT_SPI) ? pol : 1'b0;
    end
  endfunction

  // [R10] Select active level per format
  function sel_active;
    input [1:0] fmt;
    begin
      sel_active = (fmt == `SSP_FMT_SSI) ? 1'b1 : 1'b0;
    end
  endfunction

  // Left-justify so MSB goes first for any length
  function [`SSP_DATA_W-1:0] align_msb;
    input [`SSP_DATA_W-1:0] d;
    input [3:0]             sz;
    begin
      align_msb = d << (4'hF - sz);
    end
  endfunction

  // ************************************************************
  // FIFOs
  // ************************************************************
  // [R3] Independent transmit FIFO
  ssp_fifo u_tx_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wr_valid (tx_valid),
    .wr_ready (tx_ready),
    .wr_data  (tx_data),
    .rd_valid (tx_q_valid),
    .rd_ready (tx_pop),
    .rd_data  (tx_q),
    .level    (tx_level)
  );

  // [R3] Independent receive FIFO
  ssp_fifo u_rx_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wr_valid (rx_push),
    .wr_ready (rx_wr_ready),
    .wr_data  (rx_word_r),
    .rd_valid (rx_valid),
    .rd_ready (rx_ready),
    .rd_data  (rx_data),
    .level    (rx_level)
  );

  assign rx_push = rx_push_r;
  assign busy    = (st_r != ST_IDLE);

  // ************************************************************
  // Input sampling
  // ************************************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      sclk_s_r <= 2'h0;
      fs_s_r   <= 2'h0;
      miso_s_r <= 2'h0;
      mosi_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
      fs_d_r   <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], sclk_in};
      fs_s_r   <= {fs_s_r[0], frame_sync_line_in};
      miso_s_r <= {miso_s_r[0], miso_in};
      mosi_s_r <= {mosi_s_r[0], mosi_in};
      sclk_d_r <= sclk_s_r[1];
      fs_d_r   <= fs_s_r[1];
    end
  end

  wire sclk_act  = sclk_s_r[1] ^ idle_level(bus_format, clk_polarity);
  wire sclk_prev = sclk_d_r ^ idle_level(bus_format, clk_polarity);
  wire lead_edge = sclk_act && !sclk_prev;
  wire trail_edge = !sclk_act && sclk_prev;
  // [R11] Slave selected by incoming select level
  wire slv_sel   = (fs_s_r[1] == sel_active(bus_format));
  wire ssi_pulse = fs_s_r[1] && !fs_d_r;

  // ************************************************************
  // Pin drivers
  // ************************************************************
  // [R1] Same four pins, any format
  // [R2] [R16] Directions follow role
  assign sclk_oe            = enable && master_mode;
  assign frame_sync_line_oe = enable && master_mode;
  assign mosi_oe            = enable && master_mode;
  // [R13] Slave drives return line when selected (SPI, ALT) or while busy (SSI)
  assign miso_oe = enable && !master_mode &&
                   (bus_format == `SSP_FMT_SSI ? (st_r != ST_IDLE) : slv_sel);

  // ************************************************************
  // Frame engine
  // ************************************************************
  // [R17] Master starts only with queued data
  wire m_start = enable && master_mode && tx_q_valid;
  wire s_start = enable && !master_mode &&
                 ((bus_format == `SSP_FMT_SSI) ? ssi_pulse : slv_sel);
  wire div_end = (div_r == 8'h00);
  wire frame_done_pulse = rx_push_r;
  assign tx_pop = (st_r == ST_IDLE) && (m_start || s_start) && tx_q_valid;

  // [R5] One engine, one peer per frame

  always @(posedge sys_clk) begin
    if (rst) begin
      st_r                  <= ST_IDLE;
      div_r                 <= `SSP_DIV_RST;
      bit_r                 <= 4'h0;
      phase_r               <= 1'b0;
      sh_tx_r               <= 16'h0000;
      sh_rx_r               <= 16'h0000;
      rx_push_r             <= 1'b0;
      rx_word_r             <= 16'h0000;
      size_r                <= `SSP_SIZE_MIN;
      sclk_out_r            <= 1'b0;
      frame_sync_line_out_r <= 1'b1;
      mosi_out_r            <= 1'b0;
      miso_out_r            <= 1'b0;
      overrun_r             <= 1'b0;
    end else begin
      rx_push_r <= 1'b0;
      // [R18] Set wins over clear
      if (frame_done_pulse && !rx_wr_ready) begin
        overrun_r <= 1'b1;
      end else if (overrun_clr) begin
        overrun_r <= 1'b0;
      end
      div_r <= div_end ? clk_div : div_r - 8'h01;
      case (st_r)
        ST_IDLE: begin
          // [R8] Clock parked at idle level
          sclk_out_r            <= idle_level(bus_format, clk_polarity);
          frame_sync_line_out_r <= ~sel_active(bus_format);
          phase_r               <= 1'b0;
          bit_r                 <= 4'h0;
          if (m_start || s_start) begin
            // [R4] Latch frame length, clamped to at least 4 bits
            size_r  <= (frame_size < `SSP_SIZE_MIN) ? `SSP_SIZE_MIN : frame_size;
            sh_tx_r <= align_msb(tx_q_valid ? tx_q : 16'h0000,
                                 (frame_size < `SSP_SIZE_MIN) ? `SSP_SIZE_MIN : frame_size);
            div_r   <= clk_div;
            // Stale bits would leak above short frames
            sh_rx_r <= 16'h0000;
            st_r    <= master_mode ? ST_LEAD : ST_SHIFT;
            // [R9] Select asserted before first bit
            frame_sync_line_out_r <= sel_active(bus_format);
          end
        end
        ST_LEAD: begin
          // [R14] Master presents first bit
          mosi_out_r <= sh_tx_r[15];
          if (bus_format == `SSP_FMT_SSI) begin
            frame_sync_line_out_r <= 1'b0;
          end
          if (div_end) begin
            st_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (master_mode) begin
            // [R6] Master generates serial clock
            if (div_end) begin
              sclk_out_r <= ~sclk_out_r;
              phase_r    <= ~phase_r;
              if (!phase_r) begin
                // [R12] Master samples return line, shifts in zero in ALT format
                sh_rx_r <= {sh_rx_r[14:0],
                            (bus_format == `SSP_FMT_ALT) ? 1'b0 : miso_s_r[1]};
              end else begin
                sh_tx_r    <= {sh_tx_r[14:0], 1'b0};
                mosi_out_r <= sh_tx_r[14];
                bit_r      <= bit_r + 4'h1;
                if (bit_r == size_r) begin
                  st_r <= ST_TAIL;
                end
              end
            end
          end else begin
            // [R6] [R11] Slave shifts on received clock while selected (SPI, ALT) or until the last bit (SSI)
            miso_out_r <= sh_tx_r[15];
            if (lead_edge) begin
              sh_rx_r <= {sh_rx_r[14:0], mosi_s_r[1]};
            end
            if (trail_edge) begin
              sh_tx_r <= {sh_tx_r[14:0], 1'b0};
              bit_r   <= bit_r + 4'h1;
              if (bit_r == size_r) begin
                st_r <= ST_TAIL;
              end
            end
            if (bus_format != `SSP_FMT_SSI && !slv_sel) begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_TAIL: begin
          // [R18] Completed frame pushed to receive side
          rx_word_r <= sh_rx_r;
          rx_push_r <= 1'b1;
          sclk_out_r <= idle_level(bus_format, clk_polarity);
          // [R9] Select released after data
          frame_sync_line_out_r <= ~sel_active(bus_format);
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- rtl/ssp_fifo.v ----
// Eight-entry synchronous FIFO for serial frames.
// Assumes one clock, synchronous active-high reset.
`include "ssp_consts.vh"

module ssp_fifo (
  // Clock and reset
  input  wire                      sys_clk,
  input  wire                      rst,
  // Write side
  input  wire                      wr_valid,
  output wire                      wr_ready,
  input  wire [`SSP_DATA_W-1:0]    wr_data,
  // Read side
  output wire                      rd_valid,
  input  wire                      rd_ready,
  output wire [`SSP_DATA_W-1:0]    rd_data,
  // Status
  output wire [`SSP_FIFO_AW:0]     level
);

  reg [`SSP_DATA_W-1:0] mem [0:`SSP_FIFO_DEPTH-1];
  reg [`SSP_FIFO_AW:0]  wp_r;
  reg [`SSP_FIFO_AW:0]  rp_r;
  wire                  do_wr;
  wire                  do_rd;

  assign level    = wp_r - rp_r;
  assign wr_ready = (level != 4'h8);
  assign rd_valid = (wp_r != rp_r);
  assign rd_data  = mem[rp_r[`SSP_FIFO_AW-1:0]];
  assign do_wr    = wr_valid && wr_ready;
  assign do_rd    = rd_valid && rd_ready;

  always @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wp_r[`SSP_FIFO_AW-1:0]] <= wr_data;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      wp_r <= 4'h0;
      rp_r <= 4'h0;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + 4'h1;
      end
      if (do_rd) begin
        rp_r <= rp_r + 4'h1;
      end
    end
  end

endmodule
